// *** rtl/ipcb_regs.svh ***
// Register offsets, field positions, reset values and masks of the priority bank
`ifndef IPCB_REGS_SVH
`define IPCB_REGS_SVH

// ==========================================================
// Register byte offsets on APB
`define IPCB_BANK0_OFFSET 12'h000
`define IPCB_BANK1_OFFSET 12'h004
`define IPCB_BANK2_OFFSET 12'h008
`define IPCB_BANK3_OFFSET 12'h00c
`define IPCB_BANK4_OFFSET 12'h010
`define IPCB_ENABLE_OFFSET 12'h014
`define IPCB_REQUEST_OFFSET 12'h018
`define IPCB_WINNER_OFFSET 12'h01c

// ==========================================================
// Field layout
`define IPCB_NUM_BANKS 5
`define IPCB_NUM_SRC 18
`define IPCB_FIELD_W 3
`define IPCB_FIELD3_LSB 12
`define IPCB_FIELD2_LSB 8
`define IPCB_FIELD1_LSB 4
`define IPCB_FIELD0_LSB 0

// ==========================================================
// Reset value and implemented-bit masks
`define IPCB_FIELD_RESET 3'h4
`define IPCB_LEVEL_OFF 3'h0
`define IPCB_LEVEL_MIN 3'h1
`define IPCB_LEVEL_MAX 3'h7
`define IPCB_MASK_FULL 16'h7777
`define IPCB_MASK_BANK3 16'h0777
`define IPCB_MASK_BANK4 16'h7077
`define IPCB_RESET_FULL 16'h4444
`define IPCB_RESET_BANK3 16'h0444
`define IPCB_RESET_BANK4 16'h4044
`define IPCB_NO_WINNER 5'h1f

`endif

// *** rtl/ipcb_pkg.sv ***
// Types shared by the priority bank
package ipcb_pkg;

	// ==========================================================
	// APB request bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ipcb_apb_req_t;

	// Arbitration result
	typedef struct packed {
		logic valid;
		logic [4:0] source;
		logic [2:0] level;
	} ipcb_win_t;

	// Bus slave states
	typedef enum logic [0:0] {
		IPCB_IDLE = 1'b0,
		IPCB_ACCESS = 1'b1
	} ipcb_bus_state_t;

	// Whole state of the top module
	typedef struct packed {
		ipcb_bus_state_t bus;
		logic [15:0] bank0;
		logic [15:0] bank1;
		logic [15:0] bank2;
		logic [15:0] bank3;
		logic [15:0] bank4;
		logic [17:0] enable;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		ipcb_win_t win;
		logic [53:0] levels;
	} ipcb_state_t;

endpackage

// *** rtl/ipcb_arbiter.sv ***
// Priority resolver: picks the enabled request with the highest level
`timescale 1ns/1ps
`include "ipcb_regs.svh"

module ipcb_arbiter
	import ipcb_pkg::*;
#(
	parameter int NSRC = `IPCB_NUM_SRC
) (
	// Inputs
	input wire logic [NSRC*3-1:0] levels,
	input wire logic [NSRC-1:0] request,
	input wire logic [NSRC-1:0] enable,
	// Result
	output ipcb_win_t win
);
	// ==========================================================
	// Lowest index wins a tie, so equal levels resolve in a fixed order
	always_comb begin
		logic [2:0] lvl;
		lvl = 3'h0;
		win = '{valid: 1'b0, source: `IPCB_NO_WINNER, level: `IPCB_LEVEL_OFF};
		for (int i = 0; i < NSRC; i++) begin
			lvl = levels[i*3 +: 3];
			// Level zero never competes, enable gates the request
			if (request[i] && enable[i] && lvl != `IPCB_LEVEL_OFF && lvl > win.level) begin
				win.valid = 1'b1;
				win.source = 5'(i);
				win.level = lvl;
			end
		end
	end
endmodule // ipcb_arbiter

// *** rtl/ipcb_top.sv ***
// Interrupt priority configuration bank with APB slave and resolver
// ==========================================================
// Overview of operation
// - Field code 111 means level seven, the highest a source can have.
// - Field code 001 means level one, the lowest live level, and codes between map linearly.
// - Field code 000 disables the source so it never wins arbitration.
// - Every unimplemented bit of a bank, including each nibble top bit, reads as zero.
// - At reset every implemented field holds binary 100, level four.
// - Bank 0 holds timer1, compare1, capture1 and ext_irq0 levels at 14-12, 10-8, 6-4, 2-0.
// - Bank 1 holds timer2, compare2, capture2 and dma_ch0_done levels at 14-12, 10-8, 6-4, 2-0.
// - Bank 2 holds uart1_receive, spi1_event, spi1_error and timer3 levels at 14-12 to 2-0.
// - Bank 3 has 15-11 unused and holds dma_ch1_done, adc1_done, uart1_transmit at 10-8, 6-4, 2-0.
// - Bank 4 holds pin_change at 14-12, 11-7 unused, i2c1_master at 6-4 and i2c1_slave at 2-0.
// - A source reaches arbitration only while its enable bit is set.
`timescale 1ns/1ps
`include "ipcb_regs.svh"

module ipcb_top
	import ipcb_pkg::*;
#(
	parameter int NSRC = `IPCB_NUM_SRC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt requests from peripherals, same clock
	input wire logic [NSRC-1:0] irq_request,
	// Resolved winner and per-source levels
	output logic win_valid,
	output logic [4:0] win_source,
	output logic [2:0] win_level,
	output logic [NSRC*3-1:0] src_levels
);
	// ==========================================================
	// State
	ipcb_state_t st, next_st;
	ipcb_win_t arb_win;
	logic [NSRC*3-1:0] lv;

	// Write merge: only implemented bits and enabled lanes move
	function automatic logic [15:0] merge(input logic [15:0] cur, input logic [31:0] wd,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] lane;
		lane = {{8{strb[1]}}, {8{strb[0]}}};
		merge = (cur & ~(mask & lane)) | (wd[15:0] & mask & lane);
	endfunction

	// Field extract
	function automatic logic [2:0] fld(input logic [15:0] r, input int lsb);
		fld = r[lsb +: 3];
	endfunction

	// ==========================================================
	// Source order: bank 0 fields first, each bank from high field to low
	always_comb begin
		lv = '0;
		lv[0*3 +: 3] = fld(st.bank0, `IPCB_FIELD3_LSB);
		lv[1*3 +: 3] = fld(st.bank0, `IPCB_FIELD2_LSB);
		lv[2*3 +: 3] = fld(st.bank0, `IPCB_FIELD1_LSB);
		lv[3*3 +: 3] = fld(st.bank0, `IPCB_FIELD0_LSB);
		lv[4*3 +: 3] = fld(st.bank1, `IPCB_FIELD3_LSB);
		lv[5*3 +: 3] = fld(st.bank1, `IPCB_FIELD2_LSB);
		lv[6*3 +: 3] = fld(st.bank1, `IPCB_FIELD1_LSB);
		lv[7*3 +: 3] = fld(st.bank1, `IPCB_FIELD0_LSB);
		lv[8*3 +: 3] = fld(st.bank2, `IPCB_FIELD3_LSB);
		lv[9*3 +: 3] = fld(st.bank2, `IPCB_FIELD2_LSB);
		lv[10*3 +: 3] = fld(st.bank2, `IPCB_FIELD1_LSB);
		lv[11*3 +: 3] = fld(st.bank2, `IPCB_FIELD0_LSB);
		lv[12*3 +: 3] = fld(st.bank3, `IPCB_FIELD2_LSB);
		lv[13*3 +: 3] = fld(st.bank3, `IPCB_FIELD1_LSB);
		lv[14*3 +: 3] = fld(st.bank3, `IPCB_FIELD0_LSB);
		lv[15*3 +: 3] = fld(st.bank4, `IPCB_FIELD3_LSB);
		lv[16*3 +: 3] = fld(st.bank4, `IPCB_FIELD1_LSB);
		lv[17*3 +: 3] = fld(st.bank4, `IPCB_FIELD0_LSB);
	end

	ipcb_arbiter #(.NSRC(NSRC)) u_arb (
		.levels(lv),
		.request(irq_request),
		.enable(st.enable),
		.win(arb_win)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic wr;
		logic [31:0] rd;
		wr = 1'b0;
		rd = 32'h0000_0000;
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.win = arb_win;
		next_st.levels = lv;
		case (st.bus)
			IPCB_IDLE: begin
				// Setup phase seen: answer is ready in the first access cycle
				if (psel && !penable) begin
					next_st.bus = IPCB_ACCESS;
					next_st.pready = 1'b1;
					case (paddr)
						`IPCB_BANK0_OFFSET: rd = {16'h0000, st.bank0 & `IPCB_MASK_FULL};
						`IPCB_BANK1_OFFSET: rd = {16'h0000, st.bank1 & `IPCB_MASK_FULL};
						`IPCB_BANK2_OFFSET: rd = {16'h0000, st.bank2 & `IPCB_MASK_FULL};
						`IPCB_BANK3_OFFSET: rd = {16'h0000, st.bank3 & `IPCB_MASK_BANK3};
						`IPCB_BANK4_OFFSET: rd = {16'h0000, st.bank4 & `IPCB_MASK_BANK4};
						`IPCB_ENABLE_OFFSET: rd = {14'h0000, st.enable};
						`IPCB_REQUEST_OFFSET: rd = {14'h0000, irq_request};
						`IPCB_WINNER_OFFSET: rd = {23'h000000, st.win.valid, st.win.source,
							st.win.level};
						default: next_st.pslverr = 1'b1;
					endcase
					next_st.prdata = pwrite ? 32'h0000_0000 : rd;
				end
			end
			IPCB_ACCESS: begin
				next_st.bus = IPCB_IDLE;
				next_st.prdata = 32'h0000_0000;
				// Write lands at the edge where the master sees pready
				wr = psel && penable && pwrite && st.pready;
				if (wr) begin
					case (paddr)
						`IPCB_BANK0_OFFSET: next_st.bank0 = merge(st.bank0, pwdata, pstrb,
							`IPCB_MASK_FULL);
						`IPCB_BANK1_OFFSET: next_st.bank1 = merge(st.bank1, pwdata, pstrb,
							`IPCB_MASK_FULL);
						`IPCB_BANK2_OFFSET: next_st.bank2 = merge(st.bank2, pwdata, pstrb,
							`IPCB_MASK_FULL);
						`IPCB_BANK3_OFFSET: next_st.bank3 = merge(st.bank3, pwdata, pstrb,
							`IPCB_MASK_BANK3);
						`IPCB_BANK4_OFFSET: next_st.bank4 = merge(st.bank4, pwdata, pstrb,
							`IPCB_MASK_BANK4);
						`IPCB_ENABLE_OFFSET: begin
							if (pstrb[0]) next_st.enable[7:0] = pwdata[7:0];
							if (pstrb[1]) next_st.enable[15:8] = pwdata[15:8];
							if (pstrb[2]) next_st.enable[17:16] = pwdata[17:16];
						end
						default: next_st.enable = st.enable;
					endcase
				end
			end
			default: next_st.bus = IPCB_IDLE;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.bus <= IPCB_IDLE;
			st.bank0 <= `IPCB_RESET_FULL;
			st.bank1 <= `IPCB_RESET_FULL;
			st.bank2 <= `IPCB_RESET_FULL;
			st.bank3 <= `IPCB_RESET_BANK3;
			st.bank4 <= `IPCB_RESET_BANK4;
			st.enable <= 18'h00000;
			st.prdata <= 32'h0000_0000;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
			st.win <= '{valid: 1'b0, source: `IPCB_NO_WINNER, level: `IPCB_LEVEL_OFF};
			st.levels <= {6{9'h124}};
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign win_valid = st.win.valid;
	assign win_source = st.win.source;
	assign win_level = st.win.level;
	assign src_levels = st.levels;

	// ==========================================================
	// Checks
	sequence s_bank_write(logic [11:0] a);
		psel && penable && pwrite && pready && paddr == a;
	endsequence

	property p_top_level;
		@(posedge pclk) disable iff (!presetn)
		(win_valid && src_levels[win_source*3 +: 3] == `IPCB_LEVEL_MAX) |->
			win_level == `IPCB_LEVEL_MAX;
	endproperty
	a_top_level: assert property (p_top_level) else $error("winner level bad");

	property p_level_nonzero;
		@(posedge pclk) disable iff (!presetn)
		win_valid |-> win_level >= `IPCB_LEVEL_MIN;
	endproperty
	a_level_nonzero: assert property (p_level_nonzero) else $error("winner below one");

	property p_disabled_never_wins;
		@(posedge pclk) disable iff (!presetn)
		win_valid |-> src_levels[win_source*3 +: 3] != `IPCB_LEVEL_OFF;
	endproperty
	a_disabled_never_wins: assert property (p_disabled_never_wins) else $error("off won");

	property p_unused_zero;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && pready && !pwrite && paddr < `IPCB_ENABLE_OFFSET |->
			(prdata & 32'hffff_8888) == 32'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

	property p_reset_value;
		@(posedge pclk) $rose(presetn) |-> st.bank0 == `IPCB_RESET_FULL
			&& st.bank3 == `IPCB_RESET_BANK3 && st.bank4 == `IPCB_RESET_BANK4;
	endproperty
	a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

	property p_bank3_unused;
		@(posedge pclk) disable iff (!presetn)
		(st.bank3 & ~`IPCB_MASK_BANK3) == 16'h0 && (st.bank4 & ~`IPCB_MASK_BANK4) == 16'h0;
	endproperty
	a_bank3_unused: assert property (p_bank3_unused) else $error("unused bit stored");

	property p_enable_gate;
		@(posedge pclk) disable iff (!presetn)
		win_valid |-> (($past(st.enable & irq_request) >> win_source) & 18'h1) != 18'h0;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("disabled source won");

	property p_write_one_cycle;
		@(posedge pclk) disable iff (!presetn)
		s_bank_write(`IPCB_BANK0_OFFSET) ##0 pstrb == 4'hf |=>
			st.bank0 == ($past(pwdata[15:0]) & `IPCB_MASK_FULL);
	endproperty
	a_write_one_cycle: assert property (p_write_one_cycle) else $error("write not taken");

	property p_ready_one;
		@(posedge pclk) disable iff (!presetn)
		psel && !penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready timing");
endmodule // ipcb_top

// *** bench/ipcb_top_test.sv ***
// Self-checking bench of the interrupt priority configuration bank
`timescale 1ns/1ps
`include "ipcb_regs.svh"

module ipcb_top_test;
	// ==========================================================
	// Stimulus and observed signals
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [17:0] irq_request = 18'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic win_valid;
	logic [4:0] win_source;
	logic [2:0] win_level;
	logic [53:0] src_levels;
	logic [31:0] rdat;
	logic rerr;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;

	always #50 pclk = ~pclk;

	ipcb_top u_ipcb_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_request(irq_request),
		.win_valid(win_valid), .win_source(win_source), .win_level(win_level),
		.src_levels(src_levels));

	// ==========================================================
	// Shared tasks
	task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Request stands until pready is seen at a rising edge; an idle edge follows
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask

	task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(rdat, exp, what);
	endtask

	// Winner outputs trail the registers and requests by one cycle
	task win_chk(input logic v, input logic [4:0] s, input logic [2:0] l);
		repeat (2) @(posedge pclk);
		chk({win_valid, win_source, win_level}, {v, s, l}, "winner");
	endtask

	// ==========================================================
	// Scenarios
	task t_reset;
		logic [15:0] rv [5];
		rv = '{16'h4444, 16'h4444, 16'h4444, 16'h0444, 16'h4044};
		chk(src_levels, {18{3'h4}}, "reset levels");
		chk({win_valid, win_source}, {1'b0, 5'h1f}, "reset winner");
		for (int i = 0; i < 5; i++) rd_chk(12'(i * 4), {16'h0, rv[i]}, "reset bank");
		$display("reset test done");
	endtask

	task t_layout;
		logic [15:0] mk [5];
		logic [2:0] lv [18];
		logic [53:0] exp;
		mk = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077};
		lv = '{1, 2, 3, 5, 1, 2, 3, 5, 1, 2, 3, 5, 2, 3, 5, 1, 3, 5};
		for (int i = 0; i < 5; i++) begin
			wr(12'(i * 4), 32'hffffffff);
			rd_chk(12'(i * 4), {16'h0, mk[i]}, "bank mask");
		end
		for (int i = 0; i < 5; i++) wr(12'(i * 4), 32'h1235);
		for (int i = 0; i < 18; i++) exp[3 * i +: 3] = lv[i];
		@(posedge pclk);
		chk(src_levels, exp, "field layout");
		apb(1'b1, 12'h004, 32'h0, 4'h0);
		rd_chk(12'h004, 32'h1235, "no lanes");
		apb(1'b1, 12'h020, 32'hffffffff, 4'hf);
		rd_chk(12'h020, 32'h0, "unmapped");
		chk(rerr, 1'b1, "unmapped error");
		$display("layout test done");
	endtask

	task t_arb;
		wr(12'h014, 32'h3ffff);
		for (int i = 0; i < 4; i++) wr(12'(i * 4), 32'h0);
		wr(12'h010, 32'h3);
		irq_request <= 18'h20001;
		// Source 17 at level three competes with every code on source 0
		for (int i = 0; i < 8; i++) begin
			wr(12'h000, 32'(i) << 12);
			win_chk(1'b1, (i >= 3) ? 5'd0 : 5'd17, (i >= 3) ? 3'(i) : 3'd3);
		end
		wr(12'h000, 32'h0);
		wr(12'h014, 32'h1ffff);
		win_chk(1'b0, 5'h1f, 3'h0);
		wr(12'h000, 32'h7000);
		wr(12'h014, 32'h3fffe);
		win_chk(1'b1, 5'd17, 3'd3);
		rd_chk(12'h014, 32'h3fffe, "enable reg");
		rd_chk(12'h018, 32'h20001, "request reg");
		rd_chk(12'h01c, {23'h0, 1'b1, 5'd17, 3'd3}, "winner reg");
		irq_request <= 18'h0;
		win_chk(1'b0, 5'h1f, 3'h0);
		$display("arbitration test done");
	endtask

	// Reset in mid-run must bring written fields and enables back to their defaults
	task t_rerun;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(src_levels, {18{3'h4}}, "rerun levels");
		rd_chk(12'h000, 32'h4444, "rerun bank0");
		rd_chk(12'h00c, 32'h0444, "rerun bank3");
		rd_chk(12'h014, 32'h0, "rerun enable");
		$display("rerun test done");
	endtask

	// ==========================================================
	// Closing report and run control
	task end_sim;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Whole run needs under two hundred cycles; the ceiling leaves wide margin
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			end_sim;
		end
	end

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_layout;
		t_arb;
		t_rerun;
		end_sim;
	end
endmodule // ipcb_top_test
